// *** rtl/tdm_rx_defs.vh ***
// What this block does
// - over-current retry resumes after timer when enabled
// - over-temperature retry resumes after timer when enabled
// - feedback from amp output or sense input
// - safe mode adds fixed 18 dB attenuation
// - shutdown pin: timed (00b) or immediate (01b)
// - shutdown delay 2/4/6/23.8 ms, reset 10b
// - rising volume steps 0.5 dB per 1/4/8 samples
// - broadcast address also answered when enabled
// - address re-detect bit clears itself
// - output polarity invert when bit set
// - switching lock to audio clocks beats spread spectrum
// - rate family bit: 48k (0) or 44.1k (1), reported only while the lock bit is set
// - auto rate detect active when bit is 0
// - bus rate 100b single, 101b double, reset 100b
// - frame starts rising (0) or falling (1) edge
// - sample left or right justified in slot
// - slot 0 starts offset bit clocks after frame
// - capture on rising (0) or falling (1) edge
// - sense word length 16/12/8 bits
// - channel select: address slot, left, right, downmix
// - word length 16/20/24/32 bits, reset 10b
// - slot length 16/24/32 bits
`ifndef TDM_RX_DEFS_VH
`define TDM_RX_DEFS_VH

// ------------------------------------------------------------
// register offsets
// ------------------------------------------------------------
`define MISC1_ADDR 8'h06
`define MISC2_ADDR 8'h07
`define PCFG0_ADDR 8'h08
`define PCFG1_ADDR 8'h09
`define PCFG2_ADDR 8'h0A

// ------------------------------------------------------------
// reset values and writable masks
// ------------------------------------------------------------
`define MISC1_RST 8'h00
`define MISC2_RST 8'h20
`define PCFG0_RST 8'h09
`define PCFG1_RST 8'h02
`define PCFG2_RST 8'h0A
`define MISC1_WMASK 8'hFC
`define PCFG1_WMASK 8'h7F

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define OC_RETRY_BIT 5
`define OT_RETRY_BIT 4
`define FB_SEL_BIT 3
`define SAFE_BIT 2
`define SD_MODE_HI 7
`define SD_MODE_LO 6
`define SD_DLY_HI 5
`define SD_DLY_LO 4
`define RAMP_HI 3
`define RAMP_LO 2
`define BCAST_BIT 1
`define REDET_BIT 0
`define INV_BIT 7
`define LOCK_BIT 6
`define FAMILY_BIT 5
`define AUTO_BIT 4
`define RATE_HI 3
`define RATE_LO 1
`define FSPOL_BIT 0
`define JUST_BIT 6
`define OFFS_HI 5
`define OFFS_LO 1
`define EDGE_BIT 0
`define SENSE_HI 7
`define SENSE_LO 6
`define CHSEL_HI 5
`define CHSEL_LO 4
`define WLEN_HI 3
`define WLEN_LO 2
`define SLEN_HI 1
`define SLEN_LO 0

// ------------------------------------------------------------
// codes and fixed values
// ------------------------------------------------------------
`define SD_IMMEDIATE 2'b01
`define RAMP_OFF 2'b11
`define CH_ADDR 2'b00
`define CH_LEFT 2'b01
`define CH_RIGHT 2'b10
`define CH_MIX 2'b11
`define SAFE_ATTN_DB 5'd18
`define BCAST_ADDR 7'h40
`define LEFT_SLOT 6'd0
`define RIGHT_SLOT 6'd1

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define CLK_MHZ 40
`define SD_T0_US 2000
`define SD_T1_US 4000
`define SD_T2_US 6000
`define SD_T3_US 23800
`define RETRY_US 1000
`define RATE_SPLIT_CYC 12'd625

`endif

// *** rtl/tdm_rx_port_misc_config.v ***
`timescale 1ns/1ps
`include "tdm_rx_defs.vh"

module tdm_rx_port_misc_config
#(
  parameter SD_CYC0 = `SD_T0_US * `CLK_MHZ,
  parameter SD_CYC1 = `SD_T1_US * `CLK_MHZ,
  parameter SD_CYC2 = `SD_T2_US * `CLK_MHZ,
  parameter SD_CYC3 = `SD_T3_US * `CLK_MHZ,
  parameter RETRY_CYC = `RETRY_US * `CLK_MHZ
)
(
  input wire clk,
  input wire sys_rst,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  input wire serial_bit_clock,
  input wire frame_sync,
  input wire serial_data,
  input wire shutdown_pin_n,
  input wire overcurrent_event,
  input wire overtemp_event,
  input wire spread_spectrum_request,
  input wire [6:0] own_address,
  input wire [6:0] bus_target_address,
  input wire [2:0] address_offset,
  input wire [7:0] volume_target,
  input wire sample_ready,
  output reg sample_valid,
  output reg [31:0] sample_data,
  output reg sample_overflow,
  output wire address_match,
  output wire address_redetect,
  output wire overcurrent_shutdown,
  output wire overtemp_shutdown,
  output wire post_filter_feedback_select,
  output wire [4:0] safe_attenuation_db,
  output wire output_polarity_invert,
  output wire switching_clock_lock,
  output wire spread_spectrum_active,
  output wire rate_family_44k1,
  output wire auto_rate_active,
  output wire double_rate_active,
  output wire [4:0] sense_word_bits,
  output reg amp_shutdown,
  output reg [7:0] volume_now
);

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function [5:0] slot_bits;
    input [1:0] code;
    begin
      case (code)
        2'b00: slot_bits = 6'd16;
        2'b01: slot_bits = 6'd24;
        default: slot_bits = 6'd32;
      endcase
    end
  endfunction

  function [5:0] word_bits;
    input [1:0] code;
    begin
      case (code)
        2'b00: word_bits = 6'd16;
        2'b01: word_bits = 6'd20;
        2'b10: word_bits = 6'd24;
        default: word_bits = 6'd32;
      endcase
    end
  endfunction

  // ------------------------------------------------------------
  // register file
  // ------------------------------------------------------------
  reg [7:0] misc1_r;
  reg [7:0] misc2_r;
  reg [7:0] pcfg0_r;
  reg [7:0] pcfg1_r;
  reg [7:0] pcfg2_r;
  wire wr_misc2;
  wire redet_nxt;

  assign wr_misc2 = reg_wr && (reg_addr == `MISC2_ADDR);
  // self clearing request
  // a fresh write of 1 in the clearing cycle wins
  assign redet_nxt = wr_misc2 & reg_wdata[`REDET_BIT];

  // writes; reserved read-only bits never store
  always @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      misc1_r <= `MISC1_RST;
      misc2_r <= `MISC2_RST;
      pcfg0_r <= `PCFG0_RST;
      pcfg1_r <= `PCFG1_RST;
      pcfg2_r <= `PCFG2_RST;
    end
    else
    begin
      misc2_r[`REDET_BIT] <= redet_nxt;
      if (reg_wr && reg_addr == `MISC1_ADDR)
        misc1_r <= reg_wdata & `MISC1_WMASK;
      if (wr_misc2)
        misc2_r[7:1] <= reg_wdata[7:1];
      if (reg_wr && reg_addr == `PCFG0_ADDR)
        pcfg0_r <= reg_wdata;
      if (reg_wr && reg_addr == `PCFG1_ADDR)
        pcfg1_r <= reg_wdata & `PCFG1_WMASK;
      if (reg_wr && reg_addr == `PCFG2_ADDR)
        pcfg2_r <= reg_wdata;
    end
  end

  // read data registered one cycle after reg_rd
  always @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      reg_rdata <= 8'h00;
    else if (reg_rd)
    begin
      case (reg_addr)
        `MISC1_ADDR: reg_rdata <= misc1_r;
        `MISC2_ADDR: reg_rdata <= misc2_r;
        `PCFG0_ADDR: reg_rdata <= pcfg0_r;
        `PCFG1_ADDR: reg_rdata <= pcfg1_r;
        `PCFG2_ADDR: reg_rdata <= pcfg2_r;
        default: reg_rdata <= 8'h00;
      endcase
    end
  end

  // ------------------------------------------------------------
  // static controls
  // ------------------------------------------------------------
  // feedback source
  assign post_filter_feedback_select = misc1_r[`FB_SEL_BIT];
  assign safe_attenuation_db = misc1_r[`SAFE_BIT] ? `SAFE_ATTN_DB : 5'd0;
  assign output_polarity_invert = pcfg0_r[`INV_BIT];
  assign switching_clock_lock = pcfg0_r[`LOCK_BIT];
  assign spread_spectrum_active = spread_spectrum_request & ~pcfg0_r[`LOCK_BIT];
  assign rate_family_44k1 = pcfg0_r[`LOCK_BIT] & pcfg0_r[`FAMILY_BIT];
  assign auto_rate_active = ~pcfg0_r[`AUTO_BIT];
  assign address_match = (bus_target_address == own_address) ||
    (misc2_r[`BCAST_BIT] && bus_target_address == `BCAST_ADDR);
  assign address_redetect = misc2_r[`REDET_BIT];
  // sense word width; reserved code reads as 16
  assign sense_word_bits = (pcfg2_r[`SENSE_HI:`SENSE_LO] == 2'b01) ? 5'd12 :
    (pcfg2_r[`SENSE_HI:`SENSE_LO] == 2'b10) ? 5'd8 : 5'd16;

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  reg [3:0] pin_s1_r;
  reg [3:0] pin_s2_r;
  reg [1:0] pin_prev_r;
  reg [2:0] warm_r;
  wire bclk_rise;
  wire bclk_fall;
  wire fs_rise;
  wire fs_fall;
  wire frame_start;
  wire cap_edge;

  always @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      pin_s1_r <= 4'hF;
      pin_s2_r <= 4'hF;
      pin_prev_r <= 2'h3;
      warm_r <= 3'b000;
    end
    else
    begin
      warm_r <= {warm_r[1:0], 1'b1};
      pin_s1_r <= {shutdown_pin_n, serial_data, frame_sync, serial_bit_clock};
      pin_s2_r <= pin_s1_r;
      pin_prev_r <= pin_s2_r[1:0];
    end
  end

  // edges masked until the pipe holds real pin levels, no false edge after reset
  assign bclk_rise = warm_r[2] & pin_s2_r[0] & ~pin_prev_r[0];
  assign bclk_fall = warm_r[2] & ~pin_s2_r[0] & pin_prev_r[0];
  assign fs_rise = warm_r[2] & pin_s2_r[1] & ~pin_prev_r[1];
  assign fs_fall = warm_r[2] & ~pin_s2_r[1] & pin_prev_r[1];
  assign frame_start = pcfg0_r[`FSPOL_BIT] ? fs_fall : fs_rise;
  assign cap_edge = pcfg1_r[`EDGE_BIT] ? bclk_fall : bclk_rise;

  // ------------------------------------------------------------
  // slot timing and sample extraction
  // ------------------------------------------------------------
  reg [4:0] off_cnt_r;
  reg [5:0] bit_cnt_r;
  reg [5:0] slot_cnt_r;
  reg in_frame_r;
  reg [31:0] shift_r;
  reg [31:0] left_r;
  wire [4:0] off_b;
  wire [5:0] bit_b;
  wire [5:0] slot_b;
  wire [5:0] slen;
  wire [5:0] wlen;
  wire [5:0] win_lo;
  wire [6:0] win_hi;
  wire in_win;
  wire [31:0] shift_nxt;
  wire [31:0] aligned;
  wire slot_end;
  wire [5:0] mono_slot;
  wire [1:0] chsel;
  wire [32:0] mix_sum;
  reg push;
  reg [31:0] push_data;
  wire in_frame_r_eff;

  // a frame edge restarts counting, even in the same cycle as a capture
  assign off_b = frame_start ? 5'd0 : off_cnt_r;
  assign bit_b = frame_start ? 6'd0 : bit_cnt_r;
  assign slot_b = frame_start ? 6'd0 : slot_cnt_r;
  // slot length; reserved code treated as 32
  assign slen = slot_bits(pcfg2_r[`SLEN_HI:`SLEN_LO]);
  // word length clipped to the slot
  assign wlen = (word_bits(pcfg2_r[`WLEN_HI:`WLEN_LO]) > slen) ? slen :
    word_bits(pcfg2_r[`WLEN_HI:`WLEN_LO]);
  // window at slot start or slot end
  assign win_lo = pcfg1_r[`JUST_BIT] ? (slen - wlen) : 6'd0;
  assign win_hi = {1'b0, win_lo} + {1'b0, wlen};
  assign in_win = (bit_b >= win_lo) && ({1'b0, bit_b} < win_hi);
  assign shift_nxt = in_win ? {shift_r[30:0], pin_s2_r[2]} : shift_r;
  assign aligned = shift_nxt << (6'd32 - wlen);
  assign slot_end = (bit_b == slen - 6'd1);
  assign mono_slot = {3'b000, address_offset};
  assign chsel = pcfg2_r[`CHSEL_HI:`CHSEL_LO];
  assign mix_sum = {left_r[31], left_r} + {aligned[31], aligned};

  // choose which finished slot goes out
  always @*
  begin
    push = 1'b0;
    push_data = aligned;
    if (in_frame_r_eff && cap_edge && off_b >= pcfg1_r[`OFFS_HI:`OFFS_LO] && slot_end)
    begin
      case (chsel)
        `CH_ADDR: push = (slot_b == mono_slot);
        `CH_LEFT: push = (slot_b == `LEFT_SLOT);
        `CH_RIGHT: push = (slot_b == `RIGHT_SLOT);
        default:
        begin
          push = (slot_b == `RIGHT_SLOT);
          push_data = mix_sum[32:1];
        end
      endcase
    end
  end

  assign in_frame_r_eff = in_frame_r | frame_start;

  // offset then slot and bit counters
  always @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      off_cnt_r <= 5'd0;
      bit_cnt_r <= 6'd0;
      slot_cnt_r <= 6'd0;
      in_frame_r <= 1'b0;
      shift_r <= 32'h00000000;
      left_r <= 32'h00000000;
    end
    else
    begin
      if (frame_start)
      begin
        in_frame_r <= 1'b1;
        off_cnt_r <= 5'd0;
        bit_cnt_r <= 6'd0;
        slot_cnt_r <= 6'd0;
        shift_r <= 32'h00000000;
      end
      if (in_frame_r_eff && cap_edge)
      begin
        if (off_b < pcfg1_r[`OFFS_HI:`OFFS_LO])
          off_cnt_r <= off_b + 5'd1;
        else
        begin
          off_cnt_r <= off_b;
          shift_r <= slot_end ? 32'h00000000 : shift_nxt;
          bit_cnt_r <= slot_end ? 6'd0 : bit_b + 6'd1;
          if (slot_end && slot_b != 6'h3F)
            slot_cnt_r <= slot_b + 6'd1;
          // left half of the downmix waits for the right slot
          if (slot_end && slot_b == `LEFT_SLOT)
            left_r <= aligned;
        end
      end
    end
  end

  // ------------------------------------------------------------
  // two-entry output buffer; the link cannot stall, so a full
  // buffer drops the new word and flags it
  // ------------------------------------------------------------
  reg [31:0] spare_r;
  reg spare_v_r;
  wire pop;

  assign pop = sample_valid & sample_ready;

  always @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      sample_valid <= 1'b0;
      sample_data <= 32'h00000000;
      spare_r <= 32'h00000000;
      spare_v_r <= 1'b0;
      sample_overflow <= 1'b0;
    end
    else
    begin
      sample_overflow <= push & sample_valid & spare_v_r & ~pop;
      if (pop)
      begin
        sample_valid <= spare_v_r | push;
        sample_data <= spare_v_r ? spare_r : push_data;
        spare_r <= push_data;
        spare_v_r <= spare_v_r & push;
      end
      else if (push && !sample_valid)
      begin
        sample_valid <= 1'b1;
        sample_data <= push_data;
      end
      else if (push && !spare_v_r)
      begin
        spare_r <= push_data;
        spare_v_r <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // rate detection from frame period
  // ------------------------------------------------------------
  reg [11:0] period_cnt_r;
  reg fast_seen_r;

  always @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      period_cnt_r <= 12'd0;
      fast_seen_r <= 1'b0;
    end
    else if (frame_start)
    begin
      period_cnt_r <= 12'd0;
      fast_seen_r <= (period_cnt_r < `RATE_SPLIT_CYC);
    end
    else if (period_cnt_r != 12'hFFF)
      period_cnt_r <= period_cnt_r + 12'd1;
  end

  // programmed rate used when detection is off
  assign double_rate_active = auto_rate_active ? fast_seen_r :
    (pcfg0_r[`RATE_HI:`RATE_LO] == 3'b101);

  // ------------------------------------------------------------
  // fault retry timers
  // ------------------------------------------------------------
  wire [1:0] fault_in;
  wire [1:0] retry_en;
  wire [1:0] fault_hold;

  assign fault_in = {overtemp_event, overcurrent_event};
  assign retry_en = {misc1_r[`OT_RETRY_BIT], misc1_r[`OC_RETRY_BIT]};

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1)
    begin : retry_gen
      reg hold_r;
      reg [31:0] cnt_r;
      // a new event restarts the wait; without retry the fault stays
      always @(posedge clk or posedge sys_rst)
      begin
        if (sys_rst)
        begin
          hold_r <= 1'b0;
          cnt_r <= 32'd0;
        end
        else if (fault_in[gi])
        begin
          hold_r <= 1'b1;
          cnt_r <= 32'd0;
        end
        else if (hold_r && retry_en[gi])
        begin
          if (cnt_r >= RETRY_CYC - 1)
            hold_r <= 1'b0;
          else
            cnt_r <= cnt_r + 32'd1;
        end
      end
      assign fault_hold[gi] = hold_r;
    end
  endgenerate

  assign overcurrent_shutdown = fault_hold[0];
  assign overtemp_shutdown = fault_hold[1];

  // ------------------------------------------------------------
  // shutdown pin handling
  // ------------------------------------------------------------
  reg [31:0] sd_cnt_r;
  reg [31:0] sd_limit;

  always @*
  begin
    case (misc2_r[`SD_DLY_HI:`SD_DLY_LO])
      2'b00: sd_limit = SD_CYC0;
      2'b01: sd_limit = SD_CYC1;
      2'b10: sd_limit = SD_CYC2;
      default: sd_limit = SD_CYC3;
    endcase
  end

  // immediate or timed; reserved codes act as timed
  always @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      amp_shutdown <= 1'b0;
      sd_cnt_r <= 32'd0;
    end
    else if (pin_s2_r[3])
    begin
      amp_shutdown <= 1'b0;
      sd_cnt_r <= 32'd0;
    end
    else if (misc2_r[`SD_MODE_HI:`SD_MODE_LO] == `SD_IMMEDIATE)
      amp_shutdown <= 1'b1;
    else if (sd_cnt_r >= sd_limit - 1)
      amp_shutdown <= 1'b1;
    else
      sd_cnt_r <= sd_cnt_r + 32'd1;
  end

  // ------------------------------------------------------------
  // volume ramp, one step per 1, 4 or 8 frames when rising
  // ------------------------------------------------------------
  reg [2:0] ramp_cnt_r;
  reg [2:0] ramp_last;

  always @*
  begin
    case (misc2_r[`RAMP_HI:`RAMP_LO])
      2'b00: ramp_last = 3'd0;
      2'b01: ramp_last = 3'd3;
      default: ramp_last = 3'd7;
    endcase
  end

  // falling and disabled ramps jump straight to target
  always @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      volume_now <= 8'h00;
      ramp_cnt_r <= 3'd0;
    end
    else if (volume_target <= volume_now || misc2_r[`RAMP_HI:`RAMP_LO] == `RAMP_OFF)
    begin
      volume_now <= volume_target;
      ramp_cnt_r <= 3'd0;
    end
    else if (frame_start)
    begin
      if (ramp_cnt_r >= ramp_last)
      begin
        volume_now <= volume_now + 8'd1;
        ramp_cnt_r <= 3'd0;
      end
      else
        ramp_cnt_r <= ramp_cnt_r + 3'd1;
    end
  end

endmodule

// *** verif/tdm_host_model.sv ***
`timescale 1ns/1ps
// ------------------------------
// host end of the serial audio link
// ------------------------------
module tdm_host_model
(
  output reg serial_bit_clock,
  output reg frame_sync,
  output reg serial_data
);
  integer n;

  // bit clock stands still low between frames
  initial
  begin
    serial_bit_clock = 1'h0;
    frame_sync = 1'h1;
    serial_data = 1'h1;
  end

  // data moves mid-low so both capture edges see a settled bit
  task send_frame(input pol, input [4:0] off, input [63:0] bits);
  begin
    frame_sync = pol;
    #207;
    frame_sync = ~pol;
    for (n = 0; n < off + 64; n = n + 1)
    begin
      #50;
      serial_data = (n < off) ? ~serial_data : bits[63 - (n - off)];
      if (n == 1)
        frame_sync = pol;
      #50 serial_bit_clock = 1'h1;
      #100 serial_bit_clock = 1'h0;
    end
    // released line shows the inverse, never the last bit
    #50 serial_data = ~serial_data;
  end
  endtask
endmodule

// *** verif/tdm_rx_port_misc_config_properties.sv ***
`timescale 1ns/1ps
module tdm_rx_port_misc_config_checker
(
  input wire clk,
  input wire sys_rst,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire overcurrent_event,
  input wire overcurrent_shutdown,
  input wire address_redetect,
  input wire post_filter_feedback_select,
  input wire [4:0] safe_attenuation_db,
  input wire output_polarity_invert,
  input wire switching_clock_lock,
  input wire spread_spectrum_active,
  input wire auto_rate_active,
  input wire [4:0] sense_word_bits
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  // write strobes per register, reserved sense code left out
  wire wr_misc1 = reg_wr && reg_addr == 8'h06;
  wire wr_misc2 = reg_wr && reg_addr == 8'h07;
  wire wr_port0 = reg_wr && reg_addr == 8'h08;
  wire wr_port2 = reg_wr && reg_addr == 8'h0A && reg_wdata[7:6] != 2'h3;
  wire [4:0] sense_exp = reg_wdata[7] ? 5'h08 : reg_wdata[6] ? 5'h0C : 5'h10;

  AST_OC_SET: assert property (overcurrent_event |=> overcurrent_shutdown)
    else $error("over-current did not shut down");
  AST_FB_SEL: assert property (wr_misc1 |=> post_filter_feedback_select == $past(reg_wdata[3]))
    else $error("feedback select wrong");
  AST_SAFE: assert property (wr_misc1 |=> safe_attenuation_db == ($past(reg_wdata[2]) ? 5'h12 : 5'h00))
    else $error("safe attenuation wrong");
  AST_REDET_CLR: assert property (address_redetect && !(wr_misc2 && reg_wdata[0]) |=> !address_redetect)
    else $error("redetect did not clear itself");
  AST_INVERT: assert property (wr_port0 |=> output_polarity_invert == $past(reg_wdata[7]))
    else $error("polarity invert wrong");
  AST_SYNC_WINS: assert property (switching_clock_lock |-> !spread_spectrum_active)
    else $error("spread spectrum active while locked");
  AST_AUTO: assert property (wr_port0 |=> auto_rate_active == !$past(reg_wdata[4]))
    else $error("auto rate sense wrong");
  AST_SENSE: assert property (wr_port2 |=> sense_word_bits == $past(sense_exp))
    else $error("sense width wrong");
endmodule

bind tdm_rx_port_misc_config tdm_rx_port_misc_config_checker prop_i (.*);

// *** verif/tdm_rx_port_misc_config_tb_top.sv ***
`timescale 1ns/1ps
module tdm_rx_port_misc_config_tb_top;
  reg clk, sys_rst, reg_wr, reg_rd, shutdown_pin_n, sample_ready, spread_spectrum_request;
  reg [7:0] reg_addr, reg_wdata, volume_target, d;
  reg [1:0] fault_ev;
  reg [6:0] own_address, bus_target_address;
  reg [2:0] address_offset;
  wire serial_bit_clock, frame_sync, serial_data, sample_valid, sample_overflow, address_match;
  wire address_redetect, post_filter_feedback_select, output_polarity_invert, switching_clock_lock;
  wire spread_spectrum_active, rate_family_44k1, auto_rate_active, double_rate_active, amp_shutdown;
  wire [1:0] flt;
  wire [4:0] safe_attenuation_db, sense_word_bits;
  wire [7:0] reg_rdata, volume_now;
  wire [31:0] sample_data;
  integer n_fail, cmp_count, n_ovf, cyc, cnt, i, k;
  localparam [47:0] RV = 48'h002009020A00;
  localparam [47:0] MK = 48'hFCFEFF7FFF00;
  localparam [39:0] SDT = 40'h14283C6400;

  // short counts keep the run brief
  tdm_rx_port_misc_config #(.SD_CYC0(20), .SD_CYC1(40), .SD_CYC2(60), .SD_CYC3(100), .RETRY_CYC(16))
  tdm_rx_port_misc_config_i
  (
    .overcurrent_event(fault_ev[0]), .overtemp_event(fault_ev[1]),
    .overcurrent_shutdown(flt[0]), .overtemp_shutdown(flt[1]), .*
  );

  tdm_host_model tdm_host_model_i
  (
    .serial_bit_clock(serial_bit_clock), .frame_sync(frame_sync), .serial_data(serial_data)
  );

  // ------------------------------
  // clock, watchdog, helpers
  // ------------------------------
  always #12.5 clk = ~clk;

  // overflow pulses last one cycle, so count them here
  always @(posedge clk)
  begin
    cyc = cyc + 1;
    if (sample_overflow === 1'h1)
      n_ovf = n_ovf + 1;
    if (cyc == 60000)
    begin
      n_fail = n_fail + 1;
      complete_run;
    end
  end

  task complete_run;
  begin
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  end
  endtask

  task chk(input [31:0] seen, input [31:0] exp, input string what);
  begin
    cmp_count = cmp_count + 1;
    if (seen !== exp)
    begin
      n_fail = n_fail + 1;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  end
  endtask

  task do_reset;
  begin
    sys_rst = 1'h1;
    repeat (8) @(negedge clk);
    sys_rst = 1'h0;
  end
  endtask

  // fresh falling edge per access
  task wr(input [7:0] a, input [7:0] v);
  begin
    @(negedge clk);
    reg_addr = a;
    reg_wdata = v;
    reg_wr = 1'h1;
    @(negedge clk);
    reg_wr = 1'h0;
  end
  endtask

  task rd(input [7:0] a);
  begin
    @(negedge clk);
    reg_addr = a;
    reg_rd = 1'h1;
    @(negedge clk);
    reg_rd = 1'h0;
    d = reg_rdata;
  end
  endtask

  task pop(input [31:0] exp);
  begin
    @(negedge clk);
    cnt = 0;
    while (sample_valid !== 1'h1 && cnt < 2000)
    begin
      @(negedge clk);
      cnt = cnt + 1;
    end
    chk(sample_data, exp, "sample");
    sample_ready = 1'h1;
    @(negedge clk);
    sample_ready = 1'h0;
  end
  endtask

  task frame_pop(input pol, input [4:0] off, input [63:0] bits, input [31:0] exp);
  begin
    tdm_host_model_i.send_frame(pol, off, bits);
    pop(exp);
  end
  endtask

  // ------------------------------
  // scenarios
  // ------------------------------
  task t_regs;
  begin
    for (i = 0; i < 6; i = i + 1)
    begin
      rd(8'h06 + i[7:0]);
      chk(d, RV[47 - 8 * i -: 8], "reset value");
      wr(8'h06 + i[7:0], 8'hFF);
      rd(8'h06 + i[7:0]);
      chk(d, MK[47 - 8 * i -: 8], "write mask");
      wr(8'h06 + i[7:0], RV[47 - 8 * i -: 8]);
    end
  end
  endtask

  task t_static;
  begin
    wr(8'h07, 8'h21);
    chk(address_redetect, 1, "redetect set");
    @(negedge clk);
    chk(address_redetect, 0, "redetect clear");
    wr(8'h06, 8'h0C);
    chk({post_filter_feedback_select, safe_attenuation_db}, 6'h32, "safe and feedback");
    wr(8'h06, 8'h00);
    chk({post_filter_feedback_select, safe_attenuation_db}, 6'h00, "safe and feedback");
    spread_spectrum_request = 1'h1;
    wr(8'h08, 8'hEB);
    chk({output_polarity_invert, switching_clock_lock, spread_spectrum_active, rate_family_44k1}, 4'hD, "lock");
    chk({auto_rate_active, double_rate_active}, 2'h2, "rate");
    wr(8'h08, 8'h19);
    chk({output_polarity_invert, switching_clock_lock, spread_spectrum_active, rate_family_44k1}, 4'h2, "lock");
    chk({auto_rate_active, double_rate_active}, 2'h0, "rate");
    wr(8'h08, 8'h09);
    chk(auto_rate_active, 1, "rate");
    for (i = 0; i < 3; i = i + 1)
    begin
      wr(8'h0A, {i[1:0], 6'h0A});
      chk(sense_word_bits, 16 - 4 * i, "sense width");
    end
    wr(8'h0A, 8'h0A);
    bus_target_address = 7'h40;
    wr(8'h07, 8'h20);
    chk(address_match, 0, "address match");
    wr(8'h07, 8'h22);
    chk(address_match, 1, "address match");
    bus_target_address = 7'h2A;
    wr(8'h07, 8'h20);
    chk(address_match, 1, "address match");
  end
  endtask

  task t_shutdown;
  begin
    for (i = 0; i < 5; i = i + 1)
    begin
      wr(8'h07, (i < 4) ? {2'h0, i[1:0], 4'h0} : 8'h40);
      shutdown_pin_n = 1'h0;
      cnt = 0;
      while (amp_shutdown !== 1'h1 && cnt < 300)
      begin
        @(negedge clk);
        cnt = cnt + 1;
      end
      k = SDT[39 - 8 * i -: 8];
      chk(cnt >= k && cnt <= k + 5, 1, "shutdown delay");
      shutdown_pin_n = 1'h1;
      repeat (5) @(negedge clk);
      chk(amp_shutdown, 0, "shutdown release");
    end
    wr(8'h07, 8'h20);
  end
  endtask

  task t_link;
  begin
    frame_pop(1'h1, 5'h01, 64'hA5C31E7F12345678, 32'hA5C31E00);
    address_offset = 3'h1;
    frame_pop(1'h1, 5'h01, 64'hA5C31E7F12345678, 32'h12345600);
    wr(8'h0A, 8'h3A);
    frame_pop(1'h1, 5'h01, 64'h1000000020000000, 32'h18000000);
    // receiver stalls: two words kept, the third dropped
    wr(8'h0A, 8'h1A);
    k = n_ovf;
    for (i = 1; i < 4; i = i + 1)
      tdm_host_model_i.send_frame(1'h1, 5'h01, {i[7:0], 56'h0});
    chk(n_ovf - k, 1, "overflow count");
    pop(32'h01000000);
    pop(32'h02000000);
    chk(sample_valid, 0, "buffer empty");
    wr(8'h08, 8'h08);
    wr(8'h09, 8'h47);
    frame_pop(1'h0, 5'h03, 64'hA5C31E7F12345678, 32'hC31E7F00);
    wr(8'h0A, 8'h20);
    frame_pop(1'h0, 5'h03, 64'hA5C31E7F12345678, 32'h1E7F0000);
  end
  endtask

  task t_volume;
  begin
    wr(8'h07, 8'h2C);
    volume_target = 8'h04;
    repeat (2) @(negedge clk);
    chk(volume_now, 4, "volume");
    wr(8'h07, 8'h20);
    volume_target = 8'h06;
    for (i = 5; i < 7; i = i + 1)
    begin
      tdm_host_model_i.send_frame(1'h0, 5'h03, 64'h0);
      chk(volume_now, i, "volume");
    end
  end
  endtask

  task pulse(input integer f);
  begin
    fault_ev = 2'h1 << f;
    @(negedge clk);
    fault_ev = 2'h0;
    repeat (2) @(negedge clk);
    chk(flt[f], 1, "fault set");
  end
  endtask

  // ends in a reset in mid-run
  task t_fault;
  begin
    for (i = 0; i < 2; i = i + 1)
    begin
      wr(8'h06, 8'h30);
      pulse(i);
      repeat (10) @(negedge clk);
      chk(flt[i], 1, "fault hold");
      repeat (12) @(negedge clk);
      chk(flt[i], 0, "fault retry");
      wr(8'h06, 8'h00);
      pulse(i);
      repeat (40) @(negedge clk);
      chk(flt[i], 1, "fault kept");
      do_reset;
      chk(flt[i], 0, "fault reset");
    end
  end
  endtask

  // ------------------------------
  // main sequence
  // ------------------------------
  initial
  begin
    clk = 1'h0;
    reg_wr = 1'h0;
    reg_rd = 1'h0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    shutdown_pin_n = 1'h1;
    sample_ready = 1'h0;
    spread_spectrum_request = 1'h0;
    fault_ev = 2'h0;
    own_address = 7'h2A;
    bus_target_address = 7'h00;
    address_offset = 3'h0;
    volume_target = 8'h00;
    n_fail = 0;
    cmp_count = 0;
    n_ovf = 0;
    cyc = 0;
    do_reset;
    t_regs;
    t_static;
    t_shutdown;
    t_link;
    t_volume;
    t_fault;
    complete_run;
  end
endmodule
